// *** core/ovd_top.sv ***
// What this block does
// - 8-bit RW setpoint at 0x02, factory reset
// - narrow map: codes up to 0x76 give 0.6V
// - narrow map: 0x77..0xFF, 5mV steps to 1.28V
// - wide map: codes up to 0x3B give 0.6V
// - wide map: 0x3C..0x7F, 10mV steps to 1.28V
// - wide map: 0x80..0xFF, 20mV steps to 3.84V
`timescale 1ns/1ns
`include "ovd_params.svh"

module ovd_top
    import ovd_pkg::*;
#(
    parameter logic WIDE_RANGE = `OVD_WIDE_RANGE,
    parameter logic [7:0] POR_CODE = `OVD_POR_CODE
)
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input ovd_reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output ovd_target_t target_o,
    output logic target_update_o,
    output logic target_busy_o
);

    logic [7:0] output_voltage_setpoint;
    logic setpoint_hit;
    logic setpoint_wr;
    ovd_target_t decoded;
    ovd_state_t state;
    ovd_state_t next_state;

    ////////////////////////////////////////////////////////////////////////
    // address decode; only one register lives in this block
    assign setpoint_hit = (reg_req_i.addr == `OVD_SETPOINT_OFFSET);
    assign setpoint_wr = reg_req_i.wr && setpoint_hit;

    ////////////////////////////////////////////////////////////////////////
    // setpoint register, loaded with the factory code on reset
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            output_voltage_setpoint <= POR_CODE;
        end else if (setpoint_wr) begin
            output_voltage_setpoint <= reg_req_i.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // readback one cycle after the strobe; other offsets read as zero
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_req_i.rd;
            if (reg_req_i.rd) begin
                reg_rdata_o <= setpoint_hit ? output_voltage_setpoint : `OVD_UNMAPPED_RDATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decoder; the map is wired from the parameter, no register reaches it
    ovd_decode u_decode (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .wide_range_i(WIDE_RANGE),
        .output_voltage_code_i(output_voltage_setpoint),
        .target_o(decoded)
    );

    ////////////////////////////////////////////////////////////////////////
    // publish sequencer: wait for the decoder to settle, then hand over.
    // a write mid-sequence restarts it so a stale code is never published
    always_comb begin
        next_state = state;
        case (state)
            OVD_ST_IDLE: begin
                if (setpoint_wr) begin
                    next_state = OVD_ST_WAIT;
                end
            end
            OVD_ST_WAIT: begin
                next_state = setpoint_wr ? OVD_ST_WAIT : OVD_ST_PUBLISH;
            end
            OVD_ST_PUBLISH: begin
                next_state = setpoint_wr ? OVD_ST_WAIT : OVD_ST_IDLE;
            end
            default: begin
                next_state = OVD_ST_WAIT;
            end
        endcase
    end

    // reset lands in wait so the factory target is published by itself
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state <= OVD_ST_WAIT;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // target held stable between publishes; the loop never sees a half-update
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            target_o <= '{mv: `OVD_MIN_MV, step_mv: 5'h00, clamped: 1'b1, seg: OVD_SEG_CLAMP};
            target_update_o <= 1'b0;
        end else begin
            target_update_o <= 1'b0;
            if (state == OVD_ST_PUBLISH && !setpoint_wr) begin
                target_o <= decoded;
                target_update_o <= 1'b1;
            end
        end
    end

    // busy while a new code has not yet reached the target output
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            target_busy_o <= 1'b1;
        end else begin
            target_busy_o <= (next_state != OVD_ST_IDLE);
        end
    end

endmodule

// *** inc/ovd_params.svh ***
`ifndef OVD_PARAMS_SVH
`define OVD_PARAMS_SVH

// register map
`define OVD_SETPOINT_OFFSET 8'h02
`define OVD_UNMAPPED_RDATA 8'h00

// factory power-on code; arbitrary neutral value, set per variant at build
`define OVD_POR_CODE 8'h00
// variant select: 1'b0 narrow map, 1'b1 wide map
`define OVD_WIDE_RANGE 1'b0

// narrow-range map
`define OVD_NARROW_CLAMP_TOP 8'h76
`define OVD_NARROW_BASE_CODE 8'h77
`define OVD_NARROW_STEP_MV 5'h05

// wide-range map
`define OVD_WIDE_CLAMP_TOP 8'h3b
`define OVD_WIDE_LOW_CODE 8'h3c
`define OVD_WIDE_LOW_BASE_MV 12'h262
`define OVD_WIDE_LOW_STEP_MV 5'h0a
`define OVD_WIDE_HIGH_CODE 8'h80
`define OVD_WIDE_HIGH_BASE_MV 12'h514
`define OVD_WIDE_HIGH_STEP_MV 5'h14

// common floor, 0.6 V in millivolts
`define OVD_MIN_MV 12'h258

`endif

// *** inc/ovd_pkg.sv ***
package ovd_pkg;

    // which stretch of the code map a setpoint falls in
    typedef enum logic [3:0] {
        OVD_SEG_CLAMP = 4'h1,
        OVD_SEG_FINE = 4'h2,
        OVD_SEG_MID = 4'h4,
        OVD_SEG_COARSE = 4'h8
    } ovd_seg_t;

    // publish sequencer, one-hot
    typedef enum logic [2:0] {
        OVD_ST_IDLE = 3'h1,
        OVD_ST_WAIT = 3'h2,
        OVD_ST_PUBLISH = 3'h4
    } ovd_state_t;

    // one register access from the serial-bus front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ovd_reg_req_t;

    // decoded target handed to the regulation loop
    typedef struct packed {
        logic [11:0] mv;
        logic [4:0] step_mv;
        logic clamped;
        ovd_seg_t seg;
    } ovd_target_t;

endpackage

// *** core/ovd_decode.sv ***
`timescale 1ns/1ns
`include "ovd_params.svh"

module ovd_decode
    import ovd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic wide_range_i,
    input wire logic [7:0] output_voltage_code_i,
    output ovd_target_t target_o
);

    ovd_target_t next_target;
    logic [11:0] code_ext;
    logic [11:0] offs;

    ////////////////////////////////////////////////////////////////////////
    // arithmetic map instead of a 256-entry table: the steps are uniform within each segment
    always_comb begin
        code_ext = {4'h0, output_voltage_code_i};
        offs = 12'h000;
        next_target.mv = `OVD_MIN_MV;
        next_target.step_mv = 5'h00;
        next_target.clamped = 1'b1;
        next_target.seg = OVD_SEG_CLAMP;
        if (!wide_range_i) begin
            if (output_voltage_code_i > `OVD_NARROW_CLAMP_TOP) begin
                offs = code_ext - {4'h0, `OVD_NARROW_BASE_CODE};
                next_target.mv = `OVD_MIN_MV + 12'(offs * 12'h005);
                next_target.step_mv = `OVD_NARROW_STEP_MV;
                next_target.clamped = 1'b0;
                next_target.seg = OVD_SEG_FINE;
            end
        end else begin
            if (output_voltage_code_i >= `OVD_WIDE_HIGH_CODE) begin
                offs = code_ext - {4'h0, `OVD_WIDE_HIGH_CODE};
                next_target.mv = `OVD_WIDE_HIGH_BASE_MV + 12'(offs * 12'h014);
                next_target.step_mv = `OVD_WIDE_HIGH_STEP_MV;
                next_target.clamped = 1'b0;
                next_target.seg = OVD_SEG_COARSE;
            end else if (output_voltage_code_i > `OVD_WIDE_CLAMP_TOP) begin
                offs = code_ext - {4'h0, `OVD_WIDE_LOW_CODE};
                next_target.mv = `OVD_WIDE_LOW_BASE_MV + 12'(offs * 12'h00a);
                next_target.step_mv = `OVD_WIDE_LOW_STEP_MV;
                next_target.clamped = 1'b0;
                next_target.seg = OVD_SEG_MID;
            end
        end
        // codes at or below the clamp top keep the 0.6 V floor set above
    end

    ////////////////////////////////////////////////////////////////////////
    // registered result, one cycle behind the code
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            target_o <= '{mv: `OVD_MIN_MV, step_mv: 5'h00, clamped: 1'b1, seg: OVD_SEG_CLAMP};
        end else begin
            target_o <= next_target;
        end
    end

endmodule

// *** verif/ovd_checker.sv ***
`timescale 1ns/1ns
module ovd_checker
    import ovd_pkg::*;
#(
    parameter logic WIDE_RANGE = 1'b0
)
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input ovd_reg_req_t reg_req_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input ovd_target_t target_o,
    input wire logic target_update_o,
    input wire logic target_busy_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // setpoint write strobe at the mapped offset
    wire logic wr2 = reg_req_i.wr && reg_req_i.addr == 8'h02;
    wire logic [4:0] step = WIDE_RANGE ? (target_o.mv >= 12'h514 ? 5'h14 : 5'h0a) : 5'h05;
    chk_read_answer: assert property (reg_req_i.rd |=> reg_rvalid_o) else $error("read unanswered");
    chk_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_req_i.rd)) else $error("stray rvalid");
    chk_unmapped_zero: assert property (reg_req_i.rd && reg_req_i.addr != 8'h02 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_readback_value: assert property (wr2 ##1 (reg_req_i.rd && !reg_req_i.wr && reg_req_i.addr == 8'h02)
        |=> reg_rdata_o == $past(reg_req_i.wdata, 2)) else $error("readback differs");
    chk_publish_delay: assert property (wr2 ##1 !wr2 [*2] |=> target_update_o && !target_busy_o)
        else $error("publish late");
    chk_busy_pending: assert property (wr2 |=> target_busy_o && !target_update_o) else $error("busy missing");
    chk_target_stable: assert property ($changed(target_o) |-> target_update_o) else $error("target moved");
    chk_step_size: assert property (target_update_o && !target_o.clamped |-> target_o.step_mv == step)
        else $error("step wrong");
    chk_clamp_flag: assert property (target_update_o && target_o.clamped |-> target_o.mv == 12'h258
        && target_o.step_mv == 5'h00 && target_o.seg == OVD_SEG_CLAMP) else $error("clamp wrong");
endmodule
////////////////////
bind ovd_top ovd_checker #(.WIDE_RANGE(WIDE_RANGE)) u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .target_o(target_o),
    .target_update_o(target_update_o), .target_busy_o(target_busy_o));

// *** verif/ovd_host.sv ***
`timescale 1ns/1ns
module ovd_host
    import ovd_pkg::*;
(
    input wire logic clk_sys_i,
    output ovd_reg_req_t req_o
);
    initial req_o = '0;
    // one access a call; held until the next call or idle
    task automatic put(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        req_o <= '{wr: w, rd: r, addr: a, wdata: d};
    endtask
    // released lines invert so a stale value never passes
    task automatic idle();
        @(posedge clk_sys_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~req_o.addr, wdata: ~req_o.wdata};
    endtask
endmodule

// *** verif/test_output_voltage_code_decoder.sv ***
`timescale 1ns/1ns
`define OVDT_CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin bad_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module test_output_voltage_code_decoder import ovd_pkg::*;;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    ovd_reg_req_t req;
    logic [7:0] rdata [2];
    logic rvalid [2];
    ovd_target_t tgt [2];
    logic upd [2];
    logic [11:0] qt [2][$];
    logic [7:0] qr [2][$];
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [7:0] codes [8] = '{8'h00, 8'h3b, 8'h3c, 8'h76, 8'h77, 8'h7f, 8'h80, 8'hff};
    always #20 clk_sys_i = ~clk_sys_i;
    ovd_host host (.clk_sys_i(clk_sys_i), .req_o(req));
    ////////////////////
    // instance 0 narrow map, 1 wide map, same bus traffic
    for (genvar k = 0; k < 2; k++) begin : g
        ovd_top #(.WIDE_RANGE(k == 1), .POR_CODE(8'h9a)) DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
            .reg_req_i(req), .reg_rdata_o(rdata[k]), .reg_rvalid_o(rvalid[k]), .target_o(tgt[k]),
            .target_update_o(upd[k]), .target_busy_o());
        // empty queue yields x, so an extra answer counts as a mismatch
        always @(posedge clk_sys_i) begin
            logic [11:0] em;
            logic [7:0] er;
            if (!rst_i && rvalid[k] === 1'b1) begin
                er = qr[k].size() > 0 ? qr[k].pop_front() : 8'hxx;
                `OVDT_CHK("rdata", er, rdata[k])
            end
            if (!rst_i && upd[k] === 1'b1) begin
                em = qt[k].size() > 0 ? qt[k].pop_front() : 12'hxxx;
                `OVDT_CHK("target mv", em, tgt[k].mv)
            end
        end
    end
    function automatic logic [11:0] ev(input logic [7:0] c, input logic w);
        if (!w) return (c <= 8'h76) ? 12'h258 : 12'h258 + 12'h005 * (c - 8'h77);
        if (c <= 8'h3b) return 12'h258;
        if (c < 8'h80) return 12'h262 + 12'h00a * (c - 8'h3c);
        return 12'h514 + 12'h014 * (c - 8'h80);
    endfunction
    // a twice write goes back to back, only the last may publish
    task automatic set_code(input logic [7:0] c, input logic twice);
        qt[0].push_back(ev(c, 1'b0));
        qt[1].push_back(ev(c, 1'b1));
        if (twice) host.put(1'b1, 1'b0, 8'h02, ~c);
        host.put(1'b1, 1'b0, 8'h02, c);
        host.idle();
        repeat (3) @(posedge clk_sys_i);
    endtask
    task automatic read(input logic [7:0] a, input logic [7:0] e);
        qr[0].push_back(e);
        qr[1].push_back(e);
        host.put(1'b0, 1'b1, a, 8'h3c);
        host.idle();
    endtask
    // a write read back at once, then both strobes together: that read still sees the old code
    task automatic overlap(input logic [7:0] c, input logic [7:0] d);
        qt[0].push_back(ev(d, 1'b0));
        qt[1].push_back(ev(d, 1'b1));
        qr[0].push_back(c);
        qr[0].push_back(c);
        qr[1].push_back(c);
        qr[1].push_back(c);
        host.put(1'b1, 1'b0, 8'h02, c);
        host.put(1'b0, 1'b1, 8'h02, 8'h3c);
        host.put(1'b1, 1'b1, 8'h02, d);
        host.idle();
        repeat (3) @(posedge clk_sys_i);
    endtask
    task automatic complete_run();
        if (bad_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // hang guard, the run needs well under a thousand cycles
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        logic [7:0] c;
        void'($urandom(65));
        qt[0].push_back(ev(8'h9a, 1'b0));
        qt[1].push_back(ev(8'h9a, 1'b1));
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        read(8'h02, 8'h9a);
        read(8'h03, 8'h00);
        host.put(1'b1, 1'b0, 8'h03, 8'h55);
        host.idle();
        read(8'h02, 8'h9a);
        foreach (codes[i]) set_code(codes[i], i[0]);
        repeat (4) overlap(8'($urandom), 8'($urandom));
        // reset in mid-run: the factory code returns and is published again
        qt[0].push_back(ev(8'h9a, 1'b0));
        qt[1].push_back(ev(8'h9a, 1'b1));
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        read(8'h02, 8'h9a);
        for (int i = 0; i < 24; i++) begin
            c = 8'($urandom);
            set_code(c, i[0]);
            read(8'h02, c);
        end
        repeat (4) @(posedge clk_sys_i);
        `OVDT_CHK("left", 0, qt[0].size() + qt[1].size() + qr[0].size() + qr[1].size())
        complete_run();
    end
endmodule
